//--- test/tcfp_mem_model.sv
// table memory answering walk fetches
`timescale 1ns/10ps
`default_nettype none
module tcfp_mem_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mem_req,
    input wire logic [35:0] mem_addr,
    input wire logic slow,
    input wire logic err,
    output logic mem_ack,
    output logic mem_err,
    output logic [31:0] mem_rdata
);
    logic [1:0] cnt;
    logic [31:0] word;
    // levels 0-2 point onward, level 3 is a supervisor leaf
    assign word = mem_addr[11:10] == 2'h3 ? 32'h0001231A :
        {24'h0, mem_addr[11:10] + 2'h1, 6'h01};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem_ack <= 1'b0;
            cnt <= 2'h0;
            mem_err <= 1'b0;
            mem_rdata <= 32'h0;
        end
        else
        begin
            mem_ack <= mem_req && !mem_ack && (cnt == 2'h3 || !slow);
            cnt <= mem_req && !mem_ack ? cnt + 2'h1 : 2'h0;
            mem_err <= err;
            // released data flips each cycle so a stale word changes kind
            mem_rdata <= mem_req && !mem_ack ? word : ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

//--- test/translation_cache_flush_probe_bench.sv
// bench for flush and probe over axi4-lite
`timescale 1ns/10ps
`default_nettype none
module translation_cache_flush_probe_bench;
    logic aclk = 0, aresetn = 0, slow = 0, err = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, mem_req, mem_ack, mem_err, fault_wr;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [35:0] mem_addr;
    int fails = 0, comparisons = 0, acks = 0, faults = 0, cyc = 0;
    localparam logic [31:0] LEAF = 32'h0001231A;
    always #10 aclk = ~aclk;
    tcfp_top dut (.*);
    tcfp_mem_model mem (.aclk, .aresetn, .mem_req, .mem_addr, .slow,
        .err, .mem_ack, .mem_err, .mem_rdata);
    task end_sim;
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (mem_ack === 1'b1) acks <= acks + 1;
        if (fault_wr === 1'b1) faults <= faults + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            end_sim();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd_(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // probe and count the table fetches it needed
    task probe(input logic [31:0] fpv, input logic [31:0] exp, input int n);
        int a0;
        wr(8'h08, fpv);
        a0 = acks;
        rd_(8'h10);
        chk(rd, exp);
        chk(32'(acks - a0), 32'(n));
    endtask
    task t_regs;
        wr(8'h08, 32'hABCDE400);
        rd_(8'h08);
        chk(rd, 32'hABCDE400);
        rd_(8'h24);
        chk(32'(rsp), 32'h2);
        wr(8'h24, 32'h0);
        chk(32'(rsp), 32'h2);
    endtask
    task t_walk;
        probe(32'h400, LEAF, 4);
        probe(32'h400, LEAF, 0);
    endtask
    task t_flush;
        wr(8'h08, 32'h00040100);
        wr(8'h0C, 32'h0);
        probe(32'h400, LEAF, 0);
        wr(8'h08, 32'h300);
        wr(8'h0C, 32'h0);
        probe(32'h400, LEAF, 0);
        wr(8'h00, 32'h5);
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'hFFFFFFFF);
        wr(8'h00, 32'h0);
        probe(32'h400, LEAF, 4);
    endtask
    task t_reserved;
        wr(8'h08, 32'h500);
        wr(8'h0C, 32'h0);
        probe(32'h400, LEAF, 0);
        probe(32'h500, 32'h0, 0);
        wr(8'h08, 32'h400);
        wr(8'h0C, 32'h0);
        probe(32'h400, LEAF, 4);
    endtask
    task t_err;
        int f0;
        wr(8'h0C, 32'h0);
        err <= 1'b1;
        f0 = faults;
        probe(32'h01000400, 32'h0, 1);
        chk(32'(faults - f0), 32'h1);
        rd_(8'h14);
        chk(rd, 32'h1);
        rd_(8'h18);
        chk(rd, 32'h01000000);
        err <= 1'b0;
    endtask
    task t_page;
        slow <= 1'b1;
        probe(32'h0, LEAF, 4);
        probe(32'h0, LEAF, 4);
        probe(32'h100, 32'h000000C1, 3);
        probe(32'h200, 32'h00000081, 2);
        probe(32'h300, 32'h00000041, 1);
        slow <= 1'b0;
    endtask
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_walk();
        t_flush();
        t_reserved();
        t_err();
        t_page();
        end_sim();
    end
endmodule
`default_nettype wire

//--- verilog/tcfp_defs.svh
// offsets, field positions and reset values of the flush/probe block
`ifndef TCFP_DEFS_SVH
`define TCFP_DEFS_SVH
`define TCFP_OFF_CONTEXT 8'h00
`define TCFP_OFF_CTP 8'h04
`define TCFP_OFF_FP_VADDR 8'h08
`define TCFP_OFF_FLUSH 8'h0C
`define TCFP_OFF_PROBE 8'h10
`define TCFP_OFF_FSR 8'h14
`define TCFP_OFF_FAR 8'h18
`define TCFP_OFF_STATUS 8'h1C
`define TCFP_TYPE_MSB 11
`define TCFP_TYPE_LSB 8
`define TCFP_VA_LSB 12
`define TCFP_KIND_MSB 1
`define TCFP_KIND_LSB 0
`define TCFP_PERM_MSB 4
`define TCFP_PERM_LSB 2
`define TCFP_PTP_MSB 31
`define TCFP_PTP_LSB 2
`define TCFP_PERM_SUPER 3'h6
`define TCFP_CTX_W 8
`define TCFP_FSR_ERR 0
`define TCFP_FSR_LVL_LSB 8
`define TCFP_RESP_OKAY 2'h0
`define TCFP_RESP_SLVERR 2'h2
`define TCFP_RST_WORD 32'h00000000
`define TCFP_RST_CTX 8'h00
`endif

//--- verilog/tcfp_pkg.sv
// types shared by the flush/probe block
`include "tcfp_defs.svh"
package tcfp_pkg;
    typedef enum logic [1:0] {
        KIND_INVALID = 2'b00,
        KIND_POINTER = 2'b01,
        KIND_LEAF = 2'b10,
        KIND_RESERVED = 2'b11
    } tcfp_kind_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOOKUP = 3'b001,
        ST_FETCH = 3'b010,
        ST_WAIT = 3'b011,
        ST_DONE = 3'b100
    } tcfp_state_type;
    typedef struct packed {
        logic valid;
        logic is_leaf;
        logic [1:0] level;
        logic [2:0] perm;
        logic [`TCFP_CTX_W-1:0] ctx;
        logic [19:0] tag;
        logic [31:0] data;
    } tcfp_entry_type;
endpackage

//--- verilog/tcfp_top.sv
// translation cache with flush and probe logic behind an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "tcfp_defs.svh"
// Summary of operation
// R1 - flush store: type from bits 11:8, data ignored
// R2 - supervisor leaf entries flushed regardless of context
// R3 - user leaf flushed only on context match
// R4 - address tag compare width follows flush type
// R5 - leaf level tag must suit flush type
// R6 - context flush removes matching user leaf entries
// R7 - entire flush invalidates every entry
// R8 - pointer entries flushed by context and level
// R9 - flush removes at least every selected entry
// R10 - types five and above ignored or reserved
// R11 - probe uses current context register
// R12 - probe returns zero on error or non-pointer
// R13 - memory error updates fault registers, no exception
// R14 - pointer above target level fetches next level
// R15 - typed probes return target level entry
// R16 - entire probe returns first leaf found
// R17 - referenced flag left untouched by probes
// R18 - reserved probe types return a defined zero
// R19 - probe checks cache before table walk
// R20 - only entire probe loads the cache
// R21 - software keeps low address bits zero
// R22 - address: vaddr 31:12, type 11:8
// R23 - entry kind: invalid, pointer, leaf, reserved
// R24 - entry holds valid, tags, kind, access code
module tcfp_top #(
    parameter int ENTRIES = 8,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mem_req,
    output logic [35:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata,
    output logic fault_wr
);
    import tcfp_pkg::*;

    localparam int IW = $clog2(ENTRIES);

    generate
        // round robin fill pointer wraps at a power of two
        if (ENTRIES < 2 || ENTRIES > 256 || ADDR_W < 8 || ADDR_W > 32
            || (ENTRIES & (ENTRIES - 1)) != 0)
        begin : g_bad
            $error("tcfp_top: unsupported ENTRIES or ADDR_W");
        end
    endgenerate

    logic [`TCFP_CTX_W-1:0] context_reg;
    logic [31:0] ctp;
    logic [31:0] fp_vaddr;
    logic [31:0] fsr;
    logic [31:0] far_reg;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [ADDR_W-1:0] ar_addr;
    logic rd_pend;
    tcfp_state_type state;
    logic [3:0] p_type;
    logic [1:0] p_lvl;
    logic [29:0] p_tbl;
    logic [31:0] p_result;
    tcfp_entry_type cache [ENTRIES];
    logic [IW-1:0] fill_ptr;

    logic wr_go;
    logic flush_go;
    logic probe_start;
    logic [ENTRIES-1:0] valid_vec;
    logic [ENTRIES-1:0] match_vec;
    logic hit;
    logic [31:0] hit_data;
    logic fill_en;
    tcfp_kind_type kind;
    logic [1:0] tgt;
    logic entire;
    logic [9:0] idx_off;

    // bytewise merge of a register with write data
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(`TCFP_OFF_CONTEXT) || a == ADDR_W'(`TCFP_OFF_CTP)
            || a == ADDR_W'(`TCFP_OFF_FP_VADDR) || a == ADDR_W'(`TCFP_OFF_FLUSH)
            || a == ADDR_W'(`TCFP_OFF_PROBE) || a == ADDR_W'(`TCFP_OFF_FSR)
            || a == ADDR_W'(`TCFP_OFF_FAR) || a == ADDR_W'(`TCFP_OFF_STATUS);
    endfunction

    // parallel flush match for one entry
    function automatic logic flush_hit(input tcfp_entry_type e,
                                       input logic [3:0] ty,
                                       input logic [31:0] va,
                                       input logic [`TCFP_CTX_W-1:0] ctx);
        logic ctx_eq;
        logic sup;
        logic a12;
        logic a18;
        logic a24;
        logic r;
        ctx_eq = e.ctx == ctx;
        sup = e.perm >= `TCFP_PERM_SUPER;
        a12 = e.tag == va[31:12]; // [R4]
        a18 = e.tag[19:6] == va[31:18]; // [R4]
        a24 = e.tag[19:12] == va[31:24]; // [R4]
        r = 1'b0;
        if (e.is_leaf)
        begin
            case (ty)
                4'h0: r = (sup || ctx_eq) && a12 && e.level == 2'd3; // [R2] [R3] [R5]
                4'h1: r = (sup || ctx_eq) && a18 && e.level >= 2'd2; // [R2] [R3] [R5]
                4'h2: r = (sup || ctx_eq) && a24 && e.level >= 2'd1; // [R2] [R3] [R5]
                4'h3: r = !sup && ctx_eq; // [R6]
                4'h4: r = 1'b1; // [R7]
                default: r = 1'b0; // [R10]
            endcase
        end
        else
        begin
            case (ty)
                4'h0: r = ctx_eq && a12; // [R8]
                4'h1: r = ctx_eq && a18 && e.level == 2'd2; // [R8]
                4'h2: r = ctx_eq && a24 && e.level != 2'd0
                          && e.level != 2'd3; // [R8]
                4'h3: r = ctx_eq && e.level != 2'd3; // [R8]
                4'h4: r = 1'b1; // [R7]
                default: r = 1'b0; // [R10]
            endcase
        end
        return e.valid && r;
    endfunction

    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid
                   && state == ST_IDLE;
    assign flush_go = wr_go && aw_addr == ADDR_W'(`TCFP_OFF_FLUSH); // [R1]
    assign probe_start = rd_pend && !s_axi_rvalid && state == ST_IDLE
                         && ar_addr == ADDR_W'(`TCFP_OFF_PROBE);
    assign kind = tcfp_kind_type'(mem_rdata[`TCFP_KIND_MSB:`TCFP_KIND_LSB]); // [R23]
    assign entire = p_type == 4'h4;
    assign tgt = 2'd3 - p_type[1:0];
    assign fill_en = state == ST_WAIT && mem_ack && !mem_err && entire
                     && (kind == KIND_LEAF
                         || (kind == KIND_POINTER && p_lvl != 2'd3)); // [R20]

    // table index for the level being fetched
    always_comb
    begin
        case (p_lvl)
            2'd0: idx_off = {context_reg, 2'b00}; // [R11]
            2'd1: idx_off = {fp_vaddr[31:24], 2'b00};
            2'd2: idx_off = {2'b00, fp_vaddr[23:18], 2'b00};
            default: idx_off = {2'b00, fp_vaddr[17:12], 2'b00};
        endcase
    end

    // cache lookup and flush match in parallel over all entries
    always_comb
    begin
        logic lv_ok;
        logic am;
        lv_ok = 1'b0;
        am = 1'b0;
        hit = 1'b0;
        hit_data = `TCFP_RST_WORD;
        for (int i = 0; i < ENTRIES; i++)
        begin
            valid_vec[i] = cache[i].valid;
            match_vec[i] = flush_hit(cache[i], fp_vaddr[`TCFP_TYPE_MSB:`TCFP_TYPE_LSB],
                                     fp_vaddr, context_reg);
            case (cache[i].level)
                2'd0: am = 1'b1;
                2'd1: am = cache[i].tag[19:12] == fp_vaddr[31:24];
                2'd2: am = cache[i].tag[19:6] == fp_vaddr[31:18];
                default: am = cache[i].tag == fp_vaddr[31:12];
            endcase
            lv_ok = entire || cache[i].level == tgt;
            if (cache[i].valid && cache[i].is_leaf && am && lv_ok
                && (cache[i].perm >= `TCFP_PERM_SUPER
                    || cache[i].ctx == context_reg) && !hit) // [R19]
            begin
                hit = 1'b1;
                hit_data = cache[i].data;
            end
        end
    end

    // write address and data channels, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCFP_RESP_OKAY;
            aw_addr <= '0;
            w_data <= `TCFP_RST_WORD;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? `TCFP_RESP_OKAY
                                               : `TCFP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // software registers; flush data is never stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            context_reg <= `TCFP_RST_CTX;
            ctp <= `TCFP_RST_WORD;
            fp_vaddr <= `TCFP_RST_WORD;
        end
        else if (wr_go)
        begin
            if (aw_addr == ADDR_W'(`TCFP_OFF_CONTEXT))
            begin
                context_reg <= `TCFP_CTX_W'(merge({24'h000000, context_reg},
                                                  w_data, w_strb));
            end
            if (aw_addr == ADDR_W'(`TCFP_OFF_CTP))
            begin
                ctp <= merge(ctp, w_data, w_strb) & 32'hFFFFFFFC;
            end
            if (aw_addr == ADDR_W'(`TCFP_OFF_FP_VADDR))
            begin
                // reserved low byte kept as written by software [R21] [R22]
                fp_vaddr <= merge(fp_vaddr, w_data, w_strb);
            end
        end
    end

    // read channel; a probe read waits for the walk
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `TCFP_RST_WORD;
            s_axi_rresp <= `TCFP_RESP_OKAY;
            ar_addr <= '0;
            rd_pend <= 1'b0;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                ar_addr <= s_axi_araddr;
                rd_pend <= 1'b1;
            end
            if (rd_pend && !s_axi_rvalid)
            begin
                if (ar_addr == ADDR_W'(`TCFP_OFF_PROBE))
                begin
                    if (state == ST_DONE)
                    begin
                        s_axi_rdata <= p_result;
                        s_axi_rresp <= `TCFP_RESP_OKAY;
                        s_axi_rvalid <= 1'b1;
                        rd_pend <= 1'b0;
                    end
                end
                else
                begin
                    case (ar_addr)
                        ADDR_W'(`TCFP_OFF_CONTEXT):
                            s_axi_rdata <= {24'h000000, context_reg};
                        ADDR_W'(`TCFP_OFF_CTP): s_axi_rdata <= ctp;
                        ADDR_W'(`TCFP_OFF_FP_VADDR): s_axi_rdata <= fp_vaddr;
                        ADDR_W'(`TCFP_OFF_FSR): s_axi_rdata <= fsr;
                        ADDR_W'(`TCFP_OFF_FAR): s_axi_rdata <= far_reg;
                        ADDR_W'(`TCFP_OFF_STATUS):
                            s_axi_rdata <= {29'h00000000, state};
                        default: s_axi_rdata <= `TCFP_RST_WORD;
                    endcase
                    s_axi_rresp <= mapped(ar_addr) ? `TCFP_RESP_OKAY
                                                   : `TCFP_RESP_SLVERR;
                    s_axi_rvalid <= 1'b1;
                    rd_pend <= 1'b0;
                end
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // probe walk; entries are only read, so the referenced bit stays [R17]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_IDLE;
            p_type <= 4'h0;
            p_lvl <= 2'd0;
            p_tbl <= 30'h00000000;
            p_result <= `TCFP_RST_WORD;
            mem_req <= 1'b0;
            mem_addr <= 36'h000000000;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    if (probe_start)
                    begin
                        p_type <= fp_vaddr[`TCFP_TYPE_MSB:`TCFP_TYPE_LSB];
                        p_result <= `TCFP_RST_WORD;
                        if (fp_vaddr[`TCFP_TYPE_MSB:`TCFP_TYPE_LSB] > 4'h4)
                        begin
                            state <= ST_DONE; // [R10] [R18]
                        end
                        else
                        begin
                            state <= ST_LOOKUP;
                        end
                    end
                ST_LOOKUP:
                    if (hit)
                    begin
                        p_result <= hit_data; // [R19]
                        state <= ST_DONE;
                    end
                    else
                    begin
                        p_lvl <= 2'd0;
                        p_tbl <= ctp[`TCFP_PTP_MSB:`TCFP_PTP_LSB]; // [R11]
                        state <= ST_FETCH;
                    end
                ST_FETCH:
                begin
                    mem_req <= 1'b1;
                    mem_addr <= {p_tbl, 6'h00} + {26'h0000000, idx_off};
                    state <= ST_WAIT;
                end
                ST_WAIT:
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        state <= ST_DONE;
                        p_result <= `TCFP_RST_WORD; // [R12]
                        if (mem_err)
                        begin
                            p_result <= `TCFP_RST_WORD; // [R12] [R13]
                        end
                        else if (entire)
                        begin
                            if (kind == KIND_LEAF)
                            begin
                                p_result <= mem_rdata; // [R16]
                            end
                            else if (kind == KIND_POINTER && p_lvl != 2'd3)
                            begin
                                p_lvl <= p_lvl + 2'd1; // [R14]
                                p_tbl <= mem_rdata[`TCFP_PTP_MSB:`TCFP_PTP_LSB];
                                state <= ST_FETCH;
                            end
                        end
                        else if (p_lvl != tgt)
                        begin
                            if (kind == KIND_POINTER)
                            begin
                                p_lvl <= p_lvl + 2'd1; // [R14]
                                p_tbl <= mem_rdata[`TCFP_PTP_MSB:`TCFP_PTP_LSB];
                                state <= ST_FETCH;
                            end
                        end
                        else if (tgt == 2'd3)
                        begin
                            if (kind == KIND_LEAF || kind == KIND_INVALID)
                            begin
                                p_result <= mem_rdata; // [R15]
                            end
                        end
                        else if (kind != KIND_RESERVED)
                        begin
                            p_result <= mem_rdata; // [R15]
                        end
                    end
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // fault registers on a memory error; no exception goes to the core
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fsr <= `TCFP_RST_WORD;
            far_reg <= `TCFP_RST_WORD;
            fault_wr <= 1'b0;
        end
        else
        begin
            fault_wr <= state == ST_WAIT && mem_ack && mem_err; // [R13]
            if (state == ST_WAIT && mem_ack && mem_err)
            begin
                fsr <= 32'(p_lvl) << `TCFP_FSR_LVL_LSB
                       | 32'h1 << `TCFP_FSR_ERR; // [R13]
                far_reg <= {fp_vaddr[31:12], 12'h000};
            end
        end
    end

    // cache contents: flush invalidates, entire probe fills round robin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fill_ptr <= '0;
            for (int i = 0; i < ENTRIES; i++)
            begin
                cache[i] <= '0;
            end
        end
        else if (flush_go)
        begin
            for (int i = 0; i < ENTRIES; i++)
            begin
                if (match_vec[i])
                begin
                    cache[i].valid <= 1'b0; // [R9]
                end
            end
        end
        else if (fill_en)
        begin
            cache[fill_ptr] <= '{valid: 1'b1, // [R24]
                is_leaf: kind == KIND_LEAF,
                level: p_lvl,
                perm: mem_rdata[`TCFP_PERM_MSB:`TCFP_PERM_LSB],
                ctx: context_reg,
                tag: fp_vaddr[31:12],
                data: mem_rdata}; // [R20]
            fill_ptr <= fill_ptr + IW'(1);
        end
    end

    a_flush_removes: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
        flush_go |=> (valid_vec & $past(match_vec)) == '0)
        else $error("flushed entry still valid");
    a_entire_flush: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        flush_go && fp_vaddr[11:8] == 4'h4 |=> valid_vec == '0)
        else $error("entire flush left an entry");
    a_reserved_flush: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        flush_go && fp_vaddr[11:8] > 4'h4 |=> $stable(valid_vec))
        else $error("reserved flush changed cache");
    a_flush_answer: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
        flush_go |=> s_axi_bvalid && s_axi_bresp == 2'h0)
        else $error("flush not answered");
    a_error_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        state == ST_WAIT && mem_ack && mem_err
        |=> state == ST_DONE && p_result == 32'h0 ##1 state == ST_IDLE)
        else $error("memory error gave nonzero probe");
    a_fault_update: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
        state == ST_WAIT && mem_ack && mem_err
        |=> fault_wr && fsr[0] && far_reg[31:12] == fp_vaddr[31:12])
        else $error("fault registers not updated");
    a_reserved_probe: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
        probe_start && fp_vaddr[11:8] > 4'h4 |=> state == ST_DONE
        && p_result == 32'h0)
        else $error("reserved probe not zero");
    a_lookup_first: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
        probe_start && fp_vaddr[11:8] <= 4'h4 |=> state == ST_LOOKUP)
        else $error("walk started before lookup");
    a_walk_descend: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        state == ST_WAIT && mem_ack && !mem_err && !entire
        && kind == KIND_POINTER && p_lvl != tgt
        |=> state == ST_FETCH && p_lvl == $past(p_lvl) + 2'd1 ##1 mem_req)
        else $error("pointer did not descend");
    a_typed_no_fill: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
        state == ST_WAIT && mem_ack && !entire
        |=> $stable(valid_vec) && $stable(fill_ptr))
        else $error("typed probe filled the cache");
    c_entire_flush: cover property (@(posedge aclk) disable iff (!aresetn)
        flush_go && fp_vaddr[11:8] == 4'h4 && valid_vec != '0);
    c_probe_hit: cover property (@(posedge aclk) disable iff (!aresetn)
        state == ST_LOOKUP && hit);
    c_walk_leaf: cover property (@(posedge aclk) disable iff (!aresetn)
        fill_en && kind == KIND_LEAF);
    c_mem_error: cover property (@(posedge aclk) disable iff (!aresetn)
        state == ST_WAIT && mem_ack && mem_err);
endmodule
`default_nettype wire
